// ==== flash_protect_regs.svh ====
`ifndef FLASH_PROTECT_REGS_SVH
`define FLASH_PROTECT_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_ADDR_REG     12'h000
`define OFF_DATA_REG     12'h004
`define OFF_CTRL_REG     12'h008
`define OFF_RAW_STAT     12'h00C
`define OFF_INT_MASK     12'h010
`define OFF_MASK_STAT    12'h014
`define OFF_READ_EN      12'h130
`define OFF_PROG_EN      12'h134
`define OFF_TICK_RELOAD  12'h140

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_KEY         16'hA442
`define CTRL_KEY_LSB     16
`define CTRL_PROG_BIT    0
`define CTRL_ERASE_BIT   1
`define CTRL_MASS_BIT    2
`define CTRL_COMMIT_BIT  3

// ----------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------
`define STAT_ACCESS_BIT  0
`define STAT_READ_BIT    1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define PROT_RESET       8'hFF
`define CLK_MHZ          200
`define PROG_US_DEFAULT  20
`define ERASE_US_DEFAULT 100
`define MASS_US_DEFAULT  200
`define COMMIT_US_DEFAULT 20

`endif

// ==== flash_protect_pkg.sv ====
package flash_protect_pkg;

  // Operation engine states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_PULSE = 3'b010,
    S_SWEEP = 3'b100
  } eng_state_e;

  // Flash operations, coded as their control register bits
  typedef enum logic [3:0] {
    OP_PROG   = 4'b0001,
    OP_ERASE  = 4'b0010,
    OP_MASS   = 4'b0100,
    OP_COMMIT = 4'b1000
  } flash_op_e;

endpackage

// ==== flash_protect_and_timing.sv ====
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "flash_protect_regs.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module flash_protect_and_timing #(
  parameter int NBLOCKS     = 8,
  parameter int FLASH_BYTES = 16384,
  parameter int PROG_US     = `PROG_US_DEFAULT,
  parameter int ERASE_US    = `ERASE_US_DEFAULT,
  parameter int MASS_US     = `MASS_US_DEFAULT,
  parameter int COMMIT_US   = `COMMIT_US_DEFAULT
) (
  // Clock and resets
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        factory_init_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Flash read port
  input  wire logic        rd_req,
  input  wire logic [13:0] rd_addr,
  input  wire logic        rd_fetch,
  output logic      [31:0] rd_data,
  output logic             rd_valid,
  output logic             rd_denied,
  // Status
  output logic             flash_busy,
  output logic             fault_irq
);

  localparam int AW = $clog2(FLASH_BYTES);
  localparam int WW = AW - 2;
  localparam int WORDS = FLASH_BYTES / 4;
  localparam int BW = $clog2(NBLOCKS);
  localparam int PAGE_LOG = 8;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Block index of a word address: 2 KB = two 1 KB pages
  function automatic logic [BW-1:0] blk_of(input logic [WW-1:0] w);
    return w[WW-1 -: BW];
  endfunction

  // Microseconds of high voltage per operation
  function automatic logic [15:0] op_us(input flash_protect_pkg::flash_op_e op);
    unique case (op)
      flash_protect_pkg::OP_PROG:   return 16'(PROG_US);
      flash_protect_pkg::OP_ERASE:  return 16'(ERASE_US);
      flash_protect_pkg::OP_MASS:   return 16'(MASS_US);
      flash_protect_pkg::OP_COMMIT: return 16'(COMMIT_US);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0]         mem [WORDS];
  logic [11:0]         addr_q, addr_d;
  logic                wr_q, wr_d, rd_q, rd_d;
  logic [31:0]         hrdata_q, hrdata_d;
  logic [AW-1:0]       flash_address_reg_q, flash_address_reg_d;
  logic [31:0]         flash_data_reg_q, flash_data_reg_d;
  logic [7:0]          usec_q, usec_d;
  logic [1:0]          mask_q, mask_d, raw_q, raw_d;
  logic [NBLOCKS-1:0]  pe_q, pe_d, re_q, re_d;
  logic [NBLOCKS-1:0]  pe_nv_q, pe_nv_d, re_nv_q, re_nv_d;
  logic                load_q, load_d;
  flash_protect_pkg::eng_state_e st_q, st_d;
  flash_protect_pkg::flash_op_e  op_q, op_d, req_op;
  logic [7:0]          div_q, div_d;
  logic [15:0]         us_q, us_d;
  logic [WW-1:0]       idx_q, idx_d;
  logic [31:0]         rdata_q, rdata_d;
  logic                rvalid_q, rvalid_d, rdeny_q, rdeny_d;
  logic                acc, wsel, ctrl_go, op_ok, fault_set;
  logic                mem_prog, mem_erase, commit_pe, commit_re;
  logic [WW-1:0]       mem_idx, tgt_word;
  logic [31:0]         read_val;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Reads take one wait state so a write just before is always seen
  assign acc       = hsel & hready & htrans[1];
  assign hreadyout = ~rd_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign wsel      = wr_q;

  // Register read multiplexer; unmapped offsets read as zero
  always_comb begin
    read_val = 32'h0000_0000;
    unique case (addr_q)
      `OFF_ADDR_REG:    read_val = 32'(flash_address_reg_q);
      `OFF_DATA_REG:    read_val = flash_data_reg_q;
      `OFF_CTRL_REG:    read_val = (st_q != flash_protect_pkg::S_IDLE) ? 32'(op_q) : 32'h0;
      `OFF_RAW_STAT:    read_val = 32'(raw_q);
      `OFF_INT_MASK:    read_val = 32'(mask_q);
      `OFF_MASK_STAT:   read_val = 32'(raw_q & mask_q);
      `OFF_READ_EN:     read_val = 32'(re_q);
      `OFF_PROG_EN:     read_val = 32'(pe_q);
      `OFF_TICK_RELOAD: read_val = 32'(usec_q);
      default:          read_val = 32'h0000_0000;
    endcase
  end

  // Address phase capture and read data register
  always_comb begin
    addr_d   = acc ? haddr[11:0] : addr_q;
    wr_d     = acc & hwrite;
    rd_d     = acc & ~hwrite;
    hrdata_d = rd_q ? read_val : hrdata_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q   <= 12'h000;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      addr_q   <= addr_d;
      wr_q     <= wr_d;
      rd_q     <= rd_d;
      hrdata_q <= hrdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Control request decode
  // ----------------------------------------------------------------
  // Only a keyed control write starts anything; one op, lowest bit first
  assign ctrl_go = wsel && (addr_q == `OFF_CTRL_REG) &&
                   (hwdata[31:`CTRL_KEY_LSB] == `CTRL_KEY) &&
                   (hwdata[3:0] != 4'h0);
  assign tgt_word = flash_address_reg_q[AW-1:2];

  always_comb begin
    if (hwdata[`CTRL_PROG_BIT])
      req_op = flash_protect_pkg::OP_PROG;
    else if (hwdata[`CTRL_ERASE_BIT])
      req_op = flash_protect_pkg::OP_ERASE;
    else if (hwdata[`CTRL_MASS_BIT])
      req_op = flash_protect_pkg::OP_MASS;
    else
      req_op = flash_protect_pkg::OP_COMMIT;
  end

  // Program and erase need the block's enable; mass erase needs all
  always_comb begin
    unique case (req_op)
      flash_protect_pkg::OP_PROG:  op_ok = pe_q[blk_of(tgt_word)];
      flash_protect_pkg::OP_ERASE: op_ok = pe_q[blk_of(tgt_word)];
      flash_protect_pkg::OP_MASS:  op_ok = &pe_q;
      default:                     op_ok = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Operation engine
  // ----------------------------------------------------------------
  // Pulse length counts microseconds of usec_q+1 cycles each
  always_comb begin
    st_d      = st_q;
    op_d      = op_q;
    div_d     = div_q;
    us_d      = us_q;
    idx_d     = idx_q;
    mem_prog  = 1'b0;
    mem_erase = 1'b0;
    mem_idx   = idx_q;
    commit_pe = 1'b0;
    commit_re = 1'b0;
    fault_set = 1'b0;
    unique case (st_q)
      flash_protect_pkg::S_IDLE: begin
        if (ctrl_go) begin
          if (!op_ok) begin
            fault_set = 1'b1;
          end else begin
            op_d  = req_op;
            st_d  = flash_protect_pkg::S_PULSE;
            div_d = usec_q;
            us_d  = (op_us(req_op) == 16'h0000) ? 16'h0001 : op_us(req_op);
            // Program and erase target latched at start, so an address write while busy cannot move it; a commit reads address bit 0 at the end of its pulse
            idx_d = (req_op == flash_protect_pkg::OP_MASS) ? '0 : tgt_word;
            if (req_op == flash_protect_pkg::OP_ERASE)
              idx_d = {tgt_word[WW-1:PAGE_LOG], {PAGE_LOG{1'b0}}};
          end
        end
      end
      flash_protect_pkg::S_PULSE: begin
        // Requests arriving here are dropped on purpose
        if (div_q == 8'h00) begin
          div_d = usec_q;
          if (us_q <= 16'h0001) begin
            unique case (op_q)
              flash_protect_pkg::OP_PROG: begin
                mem_prog = 1'b1;
                st_d     = flash_protect_pkg::S_IDLE;
              end
              flash_protect_pkg::OP_ERASE, flash_protect_pkg::OP_MASS: begin
                st_d = flash_protect_pkg::S_SWEEP;
              end
              flash_protect_pkg::OP_COMMIT: begin
                commit_pe = flash_address_reg_q[0];
                commit_re = ~flash_address_reg_q[0];
                st_d      = flash_protect_pkg::S_IDLE;
              end
            endcase
          end else begin
            us_d = us_q - 16'h0001;
          end
        end else begin
          div_d = div_q - 8'h01;
        end
      end
      flash_protect_pkg::S_SWEEP: begin
        // One word per cycle; a page ends at its own boundary
        mem_erase = 1'b1;
        idx_d     = idx_q + 1'b1;
        if ((op_q == flash_protect_pkg::OP_ERASE) && (&idx_q[PAGE_LOG-1:0]))
          st_d = flash_protect_pkg::S_IDLE;
        else if (&idx_q)
          st_d = flash_protect_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q  <= flash_protect_pkg::S_IDLE;
      op_q  <= flash_protect_pkg::OP_PROG;
      div_q <= 8'h00;
      us_q  <= 16'h0000;
      idx_q <= '0;
    end else begin
      st_q  <= st_d;
      op_q  <= op_d;
      div_q <= div_d;
      us_q  <= us_d;
      idx_q <= idx_d;
    end
  end

  assign flash_busy = (st_q != flash_protect_pkg::S_IDLE);

  // Array storage; programming can only clear bits, like real cells
  always_ff @(posedge hclk) begin
    if (mem_prog)
      mem[mem_idx] <= mem[mem_idx] & flash_data_reg_q;
    else if (mem_erase)
      mem[mem_idx] <= 32'hFFFF_FFFF;
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Live protection reloads from the committed copy after reset
  always_comb begin
    flash_address_reg_d = flash_address_reg_q;
    flash_data_reg_d    = flash_data_reg_q;
    usec_d = usec_q;
    mask_d = mask_q;
    pe_d   = pe_q;
    re_d   = re_q;
    load_d = 1'b0;
    raw_d  = raw_q;
    if (wsel) begin
      unique case (addr_q)
        `OFF_ADDR_REG:    flash_address_reg_d = hwdata[AW-1:0];
        `OFF_DATA_REG:    flash_data_reg_d    = hwdata;
        `OFF_INT_MASK:    mask_d = hwdata[1:0];
        `OFF_MASK_STAT:   raw_d  = raw_q & ~hwdata[1:0];
        `OFF_READ_EN:     re_d   = re_q & hwdata[NBLOCKS-1:0];
        `OFF_PROG_EN:     pe_d   = pe_q & hwdata[NBLOCKS-1:0];
        `OFF_TICK_RELOAD: usec_d = hwdata[7:0];
        default:          flash_address_reg_d = flash_address_reg_q;
      endcase
    end
    if (load_q) begin
      pe_d = pe_nv_q;
      re_d = re_nv_q;
    end
    // A new fault wins over a clear in the same cycle
    raw_d[`STAT_ACCESS_BIT] = raw_d[`STAT_ACCESS_BIT] | fault_set;
    raw_d[`STAT_READ_BIT]   = raw_d[`STAT_READ_BIT] | rdeny_d;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_address_reg_q <= '0;
      flash_data_reg_q    <= 32'h0000_0000;
      usec_q <= 8'(`CLK_MHZ - 1);
      mask_q <= 2'h0;
      raw_q  <= 2'h0;
      pe_q   <= {NBLOCKS{1'b1}};
      re_q   <= {NBLOCKS{1'b1}};
      load_q <= 1'b1;
    end else begin
      flash_address_reg_q <= flash_address_reg_d;
      flash_data_reg_q    <= flash_data_reg_d;
      usec_q <= usec_d;
      mask_q <= mask_d;
      raw_q  <= raw_d;
      pe_q   <= pe_d;
      re_q   <= re_d;
      load_q <= load_d;
    end
  end

  // Fault interrupt is the masked view of the sticky flags
  assign fault_irq = |(raw_q & mask_q);

  // ----------------------------------------------------------------
  // Committed protection copy
  // ----------------------------------------------------------------
  // Models the non-volatile copy: survives hresetn, only ever clears
  always_comb begin
    pe_nv_d = commit_pe ? (pe_nv_q & pe_q) : pe_nv_q;
    re_nv_d = commit_re ? (re_nv_q & re_q) : re_nv_q;
  end

  always_ff @(posedge hclk or negedge factory_init_n) begin
    if (!factory_init_n) begin
      pe_nv_q <= {NBLOCKS{1'b1}};
      re_nv_q <= {NBLOCKS{1'b1}};
    end else begin
      pe_nv_q <= pe_nv_d;
      re_nv_q <= re_nv_d;
    end
  end

  // ----------------------------------------------------------------
  // Flash read port
  // ----------------------------------------------------------------
  // Fetches always pass; data reads need the block's read enable
  always_comb begin
    rvalid_d = rd_req;
    rdeny_d  = rd_req & ~rd_fetch & ~re_q[blk_of(rd_addr[AW-1:2])];
    rdata_d  = rdata_q;
    if (rd_req)
      rdata_d = rdeny_d ? 32'h0000_0000 : mem[rd_addr[AW-1:2]];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
      rdeny_q  <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      rdeny_q  <= rdeny_d;
    end
  end

  assign rd_data   = rdata_q;
  assign rd_valid  = rvalid_q;
  assign rd_denied = rdeny_q;

endmodule // flash_protect_and_timing

// ==== flash_protect_props.sv ====
`timescale 1ns/1ps
`include "flash_protect_regs.svh"
// ----------------------------------------------------------------
// Port checker for the flash protection block
// ----------------------------------------------------------------
module flash_protect_props (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Read port and status
  input wire logic        rd_req,
  input wire logic        rd_fetch,
  input wire logic [31:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        rd_denied,
  input wire logic        flash_busy
);
  logic ctrl_dp_q;
  logic ctrl_dp_d;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Data phase of a control write: the only legal cause of a new operation
  always_comb begin
    ctrl_dp_d = hsel && hready && htrans[1] && hwrite && (haddr[11:0] == `OFF_CTRL_REG);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_dp_q <= 1'b0;
    end else begin
      ctrl_dp_q <= ctrl_dp_d;
    end
  end

  chk_valid_next: assert property (rd_req |=> rd_valid)
    else $error("read port gave no answer one cycle after request");
  chk_valid_cause: assert property (rd_valid |-> $past(rd_req))
    else $error("read answer without a request");
  chk_denied_zero: assert property (rd_denied |-> rd_valid && rd_data == 32'h0)
    else $error("denied read returned stored data");
  chk_fetch_free: assert property (rd_req && rd_fetch |=> !rd_denied)
    else $error("instruction fetch was denied");
  chk_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("register read wait state wrong");
  chk_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("register write was stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_busy_cause: assert property ($rose(flash_busy) |-> $past(ctrl_dp_q) || $past(ctrl_dp_q, 2))
    else $error("operation started without a control write");
endmodule // flash_protect_props

bind flash_protect_and_timing flash_protect_props chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .rd_req(rd_req), .rd_fetch(rd_fetch), .rd_data(rd_data), .rd_valid(rd_valid),
  .rd_denied(rd_denied), .flash_busy(flash_busy)
);

// ==== flash_fetch_master.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Processor side: fetches and data reads on the flash read port
// ----------------------------------------------------------------
module flash_fetch_master (
  // Clock
  input  wire logic        hclk,
  // Request
  output logic             rd_req,
  output logic      [13:0] rd_addr,
  output logic             rd_fetch,
  // Answer
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        rd_denied
);
  // Idle from time zero so reset never sees a request
  initial begin
    rd_req   = 1'b0;
    rd_addr  = 14'h0000;
    rd_fetch = 1'b0;
  end

  // Released lines show the inverse so a stale address cannot pass for a live one
  task automatic read_word(input logic [13:0] a, input logic f,
                           output logic [31:0] d, output logic dn);
    int n;
    n = 0;
    rd_req   <= 1'b1;
    rd_addr  <= a;
    rd_fetch <= f;
    @(posedge hclk);
    rd_req   <= 1'b0;
    rd_addr  <= ~a;
    rd_fetch <= ~f;
    do begin
      @(posedge hclk);
      n++;
    end while (rd_valid !== 1'b1 && n < 8);
    d  = rd_data;
    dn = rd_denied;
  endtask
endmodule // flash_fetch_master

// ==== flash_protect_and_timing_bench.sv ====
`timescale 1ns/1ps
`include "flash_protect_regs.svh"
module flash_protect_and_timing_bench;
  logic        hclk;
  logic        hresetn;
  logic        factory_init_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rd_req;
  logic [13:0] rd_addr;
  logic        rd_fetch;
  logic [31:0] rd_data;
  logic        rd_valid;
  logic        rd_denied;
  logic        flash_busy;
  logic        fault_irq;
  logic [31:0] rv;
  logic        dn;
  logic        pe;
  logic        re;
  logic [13:0] ba;
  int          n_fail;
  int          check_count;
  int          cyc;

  assign hready = hreadyout;

  // Short pulses keep the run small; expectations follow these values
  flash_protect_and_timing #(.PROG_US(1), .ERASE_US(1), .MASS_US(2), .COMMIT_US(1)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .factory_init_n(factory_init_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_fetch(rd_fetch), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_denied(rd_denied), .flash_busy(flash_busy),
    .fault_irq(fault_irq)
  );

  flash_fetch_master mst_u (
    .hclk(hclk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_fetch(rd_fetch),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_denied(rd_denied)
  );

  // ----------------------------------------------------------------
  // Clock, checks and bus tasks
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    haddr  <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h0, q);
  endtask

  // Polls the pending bits; a hang ends in a mismatch
  task automatic wait_idle;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(`OFF_CTRL_REG, q);
      n++;
    end while (q[3:0] !== 4'h0 && n < 3000);
    if (n >= 3000) check(q, 32'h0);
  endtask

  task automatic flash_op(input logic [13:0] a, input logic [31:0] d, input logic [31:0] c);
    wr(`OFF_ADDR_REG, {18'h0, a});
    wr(`OFF_DATA_REG, d);
    wr(`OFF_CTRL_REG, c);
    wait_idle();
  endtask

  // Longest path is a mass erase of about 4500 cycles; the limit leaves wide margin
  initial begin
    #400000;
    n_fail++;
    $display("Error at %0t: run did not finish", $time);
    stop_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    check_count = 0;
    hresetn = 1'b0;
    factory_init_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    factory_init_n <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    rd(`OFF_PROG_EN, rv); check(rv, 32'h0000_00FF);
    rd(`OFF_READ_EN, rv); check(rv, 32'h0000_00FF);
    rd(`OFF_TICK_RELOAD, rv); check(rv, 32'h0000_00C7);
    wr(12'h020, 32'hFFFF_FFFF);
    rd(12'h020, rv); check(rv, 32'h0);
    wr(`OFF_TICK_RELOAD, 32'h13);
    rd(`OFF_TICK_RELOAD, rv); check(rv, 32'h13);
    // Back to the running clock before any flash change
    wr(`OFF_TICK_RELOAD, 32'(`CLK_MHZ - 1));
    wr(`OFF_CTRL_REG, 32'hA442_0004);
    rd(`OFF_CTRL_REG, rv); check(rv, 32'h4);
    wait_idle();
    mst_u.read_word(14'h0000, 1'b1, rv, dn); check(rv, 32'hFFFF_FFFF);
    mst_u.read_word(14'h3FFC, 1'b0, rv, dn); check(rv, 32'hFFFF_FFFF);
    wr(`OFF_ADDR_REG, 32'h0400);
    wr(`OFF_DATA_REG, 32'hA5A5_A5A5);
    wr(`OFF_CTRL_REG, 32'hA442_0001);
    cyc = 0;
    do begin
      @(posedge hclk);
      cyc++;
    end while (flash_busy !== 1'b0 && cyc < 1000);
    // One microsecond of CLK_MHZ cycles, plus the edge that first sees idle
    check(32'(cyc), 32'(`CLK_MHZ + 1));
    flash_op(14'h0804, 32'h1234_5678, 32'hA442_0001);
    mst_u.read_word(14'h0804, 1'b0, rv, dn); check(rv, 32'h1234_5678);
    // Page erase with a program request arriving while busy
    wr(`OFF_ADDR_REG, 32'h0800);
    wr(`OFF_CTRL_REG, 32'hA442_0002);
    wr(`OFF_CTRL_REG, 32'hA442_0001);
    rd(`OFF_CTRL_REG, rv); check(rv, 32'h2);
    wait_idle();
    mst_u.read_word(14'h0800, 1'b0, rv, dn); check(rv, 32'hFFFF_FFFF);
    mst_u.read_word(14'h0804, 1'b0, rv, dn); check(rv, 32'hFFFF_FFFF);
    mst_u.read_word(14'h0400, 1'b0, rv, dn); check(rv, 32'hA5A5_A5A5);
    // Policies: block 0 write only, 1 read only, 2 open, 3 execute only
    wr(`OFF_PROG_EN, 32'hF5);
    wr(`OFF_READ_EN, 32'hF6);
    wr(`OFF_PROG_EN, 32'hFF);
    rd(`OFF_PROG_EN, rv); check(rv, 32'hF5);
    for (int b = 0; b < 4; b++) begin
      pe = (b == 0 || b == 2);
      re = (b == 1 || b == 2);
      ba = {b[2:0], 11'h010};
      wr(`OFF_MASK_STAT, 32'h3);
      flash_op(ba, 32'h0F0F_0F0F, 32'hA442_0001);
      rd(`OFF_RAW_STAT, rv); check(rv & 32'h1, {31'h0, !pe});
      mst_u.read_word(ba, 1'b0, rv, dn);
      check(rv, re ? (pe ? 32'h0F0F_0F0F : 32'hFFFF_FFFF) : 32'h0);
      check({31'h0, dn}, {31'h0, !re});
      mst_u.read_word(ba, 1'b1, rv, dn);
      check(rv, pe ? 32'h0F0F_0F0F : 32'hFFFF_FFFF);
    end
    // Refused mass erase, interrupt masked then unmasked, then cleared
    wr(`OFF_MASK_STAT, 32'h3);
    wr(`OFF_INT_MASK, 32'h0);
    wr(`OFF_CTRL_REG, 32'hA442_0004);
    @(posedge hclk);
    check({30'h0, flash_busy, fault_irq}, 32'h0);
    rd(`OFF_RAW_STAT, rv); check(rv, 32'h1);
    wr(`OFF_INT_MASK, 32'h1);
    @(posedge hclk);
    check({31'h0, fault_irq}, 32'h1);
    wr(`OFF_MASK_STAT, 32'h1);
    @(posedge hclk);
    check({31'h0, fault_irq}, 32'h0);
    // Commit program enable only, then power-on reset
    wr(`OFF_ADDR_REG, 32'h1);
    wr(`OFF_CTRL_REG, 32'hA442_0008);
    wait_idle();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`OFF_PROG_EN, rv); check(rv, 32'hF5);
    rd(`OFF_READ_EN, rv); check(rv, 32'hFF);
    stop_test();
  end
endmodule // flash_protect_and_timing_bench
